// ===== rmp_resonant_pwm.v
// Resonant mode variable frequency PWM timing with burst control.
`timescale 1ns/1ps
`default_nettype none
`include "rmp_defines.vh"

// Functional notes
// - Dead times and edge delays step 5 ns per count.
// - Longest period is {0x42, 0x44[7:4]} in 5 ns units.
// - Shortest period is {0x46, 0x48[7:4]} in 5 ns units.
// - Output below reference lowers the switching frequency.
// - Feedback is sampled at a fixed 400 kHz rate.
// - Soft start ramps reference from highest frequency, loop closed.
// - Bits 7:6 of 0x4A enable burst operation.
// - Burst entry count is shortest period plus twice 0x4A[5:0].
// - Burst exit count is entry count plus sixteen.
// - Period shorter than entry count stops drives, enters burst.
// - Period longer than exit count restarts drives, leaves burst.
// - Auxiliary drive only gives fixed frequency, fixed duty pulses.
// - Fault response matches the fixed frequency mode.
// - Resonant mode when 0x40[5:0] is all ones.
// - 0x41 delays drive A rise from cycle start, 0 to 1275 ns.
// - Drive duty cycle stays fixed as frequency moves; the code keeps the ns edge delays fixed instead, so duty varies with period.
// - Drives A, B in first half only; C, D in second half.
module rmp_resonant_pwm #(
  parameter PW = 12,
  parameter FRAC = 4
) (
  input wire clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  output reg [7:0] reg_rdata,
  input wire pwm_enable,
  input wire fault_in,
  input wire [11:0] vref_target,
  input wire [11:0] vsense,
  output reg drive_a,
  output reg drive_b,
  output reg drive_c,
  output reg drive_d,
  output wire aux_drive,
  output reg burst_active,
  output reg soft_start_done,
  output reg fault_flag
);
  localparam AW = PW + FRAC;

  // ******************************************************
  // Helper functions.
  // ******************************************************

  // Joins an eight bit upper byte and a nibble into a period count.
  function [11:0] join_count;
    input [7:0] hi;
    input [7:0] lo;
    begin
      join_count = {hi, lo[7:4]};
    end
  endfunction

  // Converts a count of 5 ns steps into nanoseconds.
  function [15:0] to_ns;
    input [11:0] n;
    reg [18:0] p;
    begin
      p = {7'h00, n} * `RMP_LSB_NS;
      to_ns = p[15:0];
    end
  endfunction

  // ******************************************************
  // Register bank.
  // ******************************************************
  reg [7:0] fsel_q;
  reg [7:0] rise_q;
  reg [7:0] lowf_hi_q;
  reg [7:0] afall_q;
  reg [7:0] lowf_lo_q;
  reg [7:0] highf_hi_q;
  reg [7:0] highf_lo_q;
  reg [7:0] burst_q;

  // Stores software writes; unmapped addresses are ignored.
  always @(posedge clk) begin
    if (srst) begin
      fsel_q <= `RMP_REG_RESET;
      rise_q <= `RMP_REG_RESET;
      lowf_hi_q <= `RMP_REG_RESET;
      afall_q <= `RMP_REG_RESET;
      lowf_lo_q <= `RMP_REG_RESET;
      highf_hi_q <= `RMP_REG_RESET;
      highf_lo_q <= `RMP_REG_RESET;
      burst_q <= `RMP_REG_RESET;
    end else if (reg_we) begin
      case (reg_addr)
        `RMP_ADDR_FSEL: fsel_q <= reg_wdata;
        `RMP_ADDR_RISE: rise_q <= reg_wdata;
        `RMP_ADDR_LOWF_HI: lowf_hi_q <= reg_wdata;
        `RMP_ADDR_AFALL: afall_q <= reg_wdata;
        `RMP_ADDR_LOWF_LO: lowf_lo_q <= reg_wdata;
        `RMP_ADDR_HIGHF_HI: highf_hi_q <= reg_wdata;
        `RMP_ADDR_HIGHF_LO: highf_lo_q <= reg_wdata;
        `RMP_ADDR_BURST: burst_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ******************************************************
  // Mode, limits and thresholds.
  // ******************************************************
  wire resonant;
  wire running;
  wire burst_en;
  wire [11:0] max_per;
  wire [11:0] min_per;
  wire [12:0] entry_cnt;
  wire [12:0] exit_cnt;

  assign resonant = (fsel_q[5:0] == `RMP_RESONANT_CODE);
  assign max_per = join_count(lowf_hi_q, lowf_lo_q);
  assign min_per = join_count(highf_hi_q, highf_lo_q);
  assign burst_en = (burst_q[7:6] != 2'b00);
  // Entry uses twice the offset; exit adds fixed hysteresis.
  assign entry_cnt = {1'b0, min_per} + {6'h00, burst_q[5:0], 1'b0};
  assign exit_cnt = entry_cnt + `RMP_BURST_HYST;

  // Faults stop the stage in resonant mode exactly as in fixed mode.
  assign running = resonant && pwm_enable && !fault_flag;

  // Latches a fault until the stage is disabled; a new fault wins.
  always @(posedge clk) begin
    if (srst) begin
      fault_flag <= 1'b0;
    end else if (fault_in) begin
      fault_flag <= 1'b1;
    end else if (!pwm_enable) begin
      fault_flag <= 1'b0;
    end
  end

  // ******************************************************
  // Feedback loop and soft start.
  // ******************************************************
  wire sample_tick;
  reg [11:0] ref_q;
  reg [AW-1:0] acc_q;
  reg [AW-1:0] acc_d;
  reg [AW:0] acc_up;
  reg [11:0] err_mag;
  wire [11:0] req_per;
  reg [11:0] clamp_per;

  rmp_sample_tick #(
    .DIV(`RMP_SAMPLE_CYC)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(sample_tick)
  );

  // Integrating filter: a low output stretches the period.
  always @* begin
    acc_up = {1'b0, acc_q};
    err_mag = 12'h000;
    acc_d = acc_q;
    if (ref_q > vsense) begin
      err_mag = ref_q - vsense;
      acc_up = {1'b0, acc_q} + {{(AW-11){1'b0}}, err_mag};
      acc_d = acc_up[AW] ? {AW{1'b1}} : acc_up[AW-1:0];
    end else begin
      err_mag = vsense - ref_q;
      if (acc_q < {{(AW-12){1'b0}}, err_mag}) begin
        acc_d = {AW{1'b0}};
      end else begin
        acc_d = acc_q - {{(AW-12){1'b0}}, err_mag};
      end
    end
  end

  // Steps the reference ramp and the filter once per sample.
  always @(posedge clk) begin
    if (srst || !running) begin
      ref_q <= 12'h000;
      acc_q <= {min_per, {FRAC{1'b0}}};
      soft_start_done <= 1'b0;
    end else if (sample_tick) begin
      if (ref_q < vref_target) begin
        ref_q <= ref_q + 12'h001;
      end else begin
        ref_q <= vref_target;
      end
      soft_start_done <= (ref_q == vref_target);
      acc_q <= acc_d;
    end
  end

  // The period the loop asks for, before any limit is applied.
  assign req_per = acc_q[FRAC +: PW];

  // Limits the requested period to the programmed window.
  always @* begin
    if (req_per < min_per) begin
      clamp_per = min_per;
    end else if (req_per > max_per) begin
      clamp_per = max_per;
    end else begin
      clamp_per = req_per;
    end
  end

  // ******************************************************
  // Burst operation.
  // ******************************************************

  // Enters on a short requested period and leaves on a long one.
  always @(posedge clk) begin
    if (srst || !running || !burst_en) begin
      burst_active <= 1'b0;
    end else if (sample_tick) begin
      if (!burst_active && ({1'b0, req_per} < entry_cnt)) begin
        burst_active <= 1'b1;
      end else if (burst_active && ({1'b0, req_per} > exit_cnt)) begin
        burst_active <= 1'b0;
      end
    end
  end

  // ******************************************************
  // Switching cycle timebase.
  // ******************************************************
  reg [15:0] phase_q;
  reg [15:0] per_ns_q;
  wire [15:0] phase_nx;
  wire [15:0] half_ns;
  wire wrap;

  assign phase_nx = phase_q + `RMP_CLK_NS;
  assign wrap = (phase_nx >= per_ns_q);
  assign half_ns = {1'b0, per_ns_q[15:1]};

  // Tracks time within the cycle in ns; the period loads at wrap, and resets to min_per while stopped.
  always @(posedge clk) begin
    if (srst || !running) begin
      phase_q <= 16'h0000;
      per_ns_q <= to_ns(min_per);
    end else if (wrap) begin
      phase_q <= phase_nx - per_ns_q;
      per_ns_q <= to_ns(clamp_per);
    end else begin
      phase_q <= phase_nx;
    end
  end

  // ******************************************************
  // Drive edge placement.
  // ******************************************************
  wire [15:0] rise_ns;
  wire [15:0] fall_mag_ns;
  reg [15:0] a_fall_ns;
  reg [15:0] c_rise_ns;
  reg [15:0] c_fall_ns;
  reg first_on;
  reg second_on;

  // Dead times are fixed in ns, so the duty cycle within the half-cycle split varies with period.
  assign rise_ns = to_ns({4'h0, rise_q});
  assign fall_mag_ns = afall_q[`RMP_LEAD_BIT] ?
    to_ns(12'h100 - {4'h0, afall_q}) : to_ns({4'h0, afall_q});

  // Places the falling edge of A around the midpoint, then mirrors C.
  always @* begin
    if (afall_q[`RMP_LEAD_BIT]) begin
      a_fall_ns = (half_ns > fall_mag_ns) ? half_ns - fall_mag_ns
                                          : 16'h0000;
    end else begin
      a_fall_ns = half_ns + fall_mag_ns;
    end
    c_rise_ns = half_ns + rise_ns;
    c_fall_ns = a_fall_ns + half_ns;
    first_on = (phase_q >= rise_ns) && (phase_q < a_fall_ns) &&
               (phase_q < half_ns);
    second_on = (phase_q >= c_rise_ns) && (phase_q < c_fall_ns) &&
                (phase_q >= half_ns) && (phase_q < per_ns_q);
  end

  // Registers the drives; burst and faults hold drives A, B, C and D low.
  always @(posedge clk) begin
    if (srst || !running || burst_active) begin
      drive_a <= 1'b0;
      drive_b <= 1'b0;
      drive_c <= 1'b0;
      drive_d <= 1'b0;
    end else begin
      drive_a <= first_on;
      drive_b <= first_on;
      drive_c <= second_on;
      drive_d <= second_on;
    end
  end

  // ******************************************************
  // Auxiliary drive.
  // ******************************************************

  // Fixed waveform only; it ignores the loop entirely.
  rmp_aux_pwm #(
    .PERIOD(`RMP_AUX_PERIOD_CYC),
    .HIGH(`RMP_AUX_HIGH_CYC)
  ) u_aux (
    .clk(clk),
    .srst(srst),
    .enable(running),
    .aux_out(aux_drive)
  );

  // ******************************************************
  // Register read back.
  // ******************************************************

  // Returns the addressed register; unmapped addresses read as zero.
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `RMP_ADDR_FSEL: reg_rdata <= fsel_q;
        `RMP_ADDR_RISE: reg_rdata <= rise_q;
        `RMP_ADDR_LOWF_HI: reg_rdata <= lowf_hi_q;
        `RMP_ADDR_AFALL: reg_rdata <= afall_q;
        `RMP_ADDR_LOWF_LO: reg_rdata <= lowf_lo_q;
        `RMP_ADDR_HIGHF_HI: reg_rdata <= highf_hi_q;
        `RMP_ADDR_HIGHF_LO: reg_rdata <= highf_lo_q;
        `RMP_ADDR_BURST: reg_rdata <= burst_q;
        `RMP_ADDR_STATUS: reg_rdata <= {4'h0, fault_flag,
          soft_start_done, burst_active, resonant};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // rmp_resonant_pwm
`default_nettype wire

// ===== rmp_defines.vh
// Constants shared by the resonant mode PWM timing block.
`ifndef RMP_DEFINES_VH
`define RMP_DEFINES_VH

// ******************************************************
// Register addresses.
// ******************************************************
`define RMP_ADDR_FSEL 8'h40
`define RMP_ADDR_RISE 8'h41
`define RMP_ADDR_LOWF_HI 8'h42
`define RMP_ADDR_AFALL 8'h43
`define RMP_ADDR_LOWF_LO 8'h44
`define RMP_ADDR_HIGHF_HI 8'h46
`define RMP_ADDR_HIGHF_LO 8'h48
`define RMP_ADDR_BURST 8'h4A
`define RMP_ADDR_STATUS 8'h3E

// ******************************************************
// Field layouts, codes and reset values.
// ******************************************************
`define RMP_REG_RESET 8'h00
`define RMP_RESONANT_CODE 6'h3F
`define RMP_BURST_HYST 13'h0010
`define RMP_LEAD_BIT 7

// ******************************************************
// Timing constants.
// ******************************************************
`define RMP_LSB_NS 19'h00005
`define RMP_CLK_NS 16'h0008
`define RMP_SAMPLE_NS 2500
`define RMP_SAMPLE_CYC (`RMP_SAMPLE_NS / `RMP_CLK_NS)
`define RMP_AUX_PERIOD_NS 10000
`define RMP_AUX_HIGH_NS 5000
`define RMP_AUX_PERIOD_CYC (`RMP_AUX_PERIOD_NS / `RMP_CLK_NS)
`define RMP_AUX_HIGH_CYC (`RMP_AUX_HIGH_NS / `RMP_CLK_NS)

`endif

// ===== rmp_sample_tick.v
// Fixed rate enable pulse that paces the feedback sampling.
`timescale 1ns/1ps
`default_nettype none
module rmp_sample_tick #(
  parameter DIV = 312
) (
  input wire clk,
  input wire srst,
  output reg tick
);
  reg [15:0] cnt_q;

  // Counts down one sampling interval and pulses at its end.
  always @(posedge clk) begin
    if (srst) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= DIV[15:0] - 16'h0001;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // rmp_sample_tick
`default_nettype wire

// ===== rmp_aux_pwm.v
// Fixed frequency, fixed duty waveform for the auxiliary drive.
`timescale 1ns/1ps
`default_nettype none
module rmp_aux_pwm #(
  parameter PERIOD = 1250,
  parameter HIGH = 625
) (
  input wire clk,
  input wire srst,
  input wire enable,
  output reg aux_out
);
  reg [15:0] cnt_q;

  // Free running period counter; the output is high for the first part.
  always @(posedge clk) begin
    if (srst || !enable) begin
      cnt_q <= 16'h0000;
      aux_out <= 1'b0;
    end else begin
      if (cnt_q == PERIOD[15:0] - 16'h0001) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
      aux_out <= (cnt_q < HIGH[15:0]);
    end
  end
endmodule // rmp_aux_pwm
`default_nettype wire

// ===== rmp_switch_model.sv
// Behavioural model of the power switch stage driven by the block.
`timescale 1ns/1ps
`default_nettype none
module rmp_switch_model (
  input wire logic clk,
  input wire logic leg_a,
  input wire logic leg_b,
  input wire logic leg_c,
  input wire logic leg_d,
  output var logic [15:0] short_cnt
);
  // ****************************************
  // Shoot-through monitor.
  // ****************************************
  initial short_cnt = 16'h0000;
  // Counts cycles where both halves of the bridge conduct at once.
  always @(posedge clk) begin
    if ((leg_a || leg_b) && (leg_c || leg_d)) begin
      short_cnt <= short_cnt + 16'h0001;
    end
  end
endmodule // rmp_switch_model
`default_nettype wire

// ===== rmp_resonant_pwm_props.sv
// Port level assertions for the resonant mode PWM timing block.
`timescale 1ns/1ps
`default_nettype none
`include "rmp_defines.vh"
module rmp_resonant_pwm_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic [7:0] reg_rdata,
  input wire logic pwm_enable,
  input wire logic fault_in,
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic drive_c,
  input wire logic drive_d,
  input wire logic aux_drive,
  input wire logic burst_active,
  input wire logic fault_flag
);
  // ****************************************
  // Aux waveform timer.
  // ****************************************
  logic aux_q;
  logic aux_seen_q;
  logic [11:0] aux_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Times aux edges only while the stage runs without a fault.
  always @(posedge clk) begin
    aux_q <= srst ? 1'b0 : aux_drive;
    if (srst || !pwm_enable || fault_flag ||
        (reg_we && reg_addr == `RMP_ADDR_FSEL)) aux_seen_q <= 1'b0;
    else if (aux_drive && !aux_q) aux_seen_q <= 1'b1;
    if (aux_drive && !aux_q) aux_cnt_q <= 12'h001;
    else if (aux_cnt_q != 12'hFFF) aux_cnt_q <= aux_cnt_q + 12'h001;
  end
  // ****************************************
  // Assertions.
  // ****************************************
  AST_AB_PAIR: assert property (drive_a == drive_b)
    else $error("drive b differs from drive a");
  AST_CD_PAIR: assert property (drive_c == drive_d)
    else $error("drive d differs from drive c");
  AST_HALF_EXCL: assert property (!(drive_a && drive_c))
    else $error("both half cycle drives high");
  AST_BURST_QUIET: assert property (burst_active && $past(burst_active) |-> !drive_a && !drive_c)
    else $error("drives active in burst");
  AST_FAULT_SET: assert property (fault_in |=> fault_flag)
    else $error("fault not latched");
  AST_FAULT_CLR: assert property (!pwm_enable && !fault_in |=> !fault_flag)
    else $error("fault not cleared by disable");
  AST_FAULT_QUIET: assert property (fault_flag && $past(fault_flag) |-> !drive_a && !drive_c)
    else $error("drives active under fault");
  AST_MODE_RDBK: assert property ((reg_we && reg_addr == `RMP_ADDR_FSEL) ##1
    (!reg_we && reg_addr == `RMP_ADDR_FSEL) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mode register readback wrong");
  AST_IDLE: assert property (!pwm_enable && !$past(pwm_enable) |-> !drive_a && !drive_c)
    else $error("drives active while disabled");
  AST_AUX_PERIOD: assert property (aux_drive && !aux_q && aux_seen_q |-> aux_cnt_q == `RMP_AUX_PERIOD_CYC)
    else $error("aux period wrong");
  AST_AUX_HIGH: assert property (!aux_drive && aux_q && aux_seen_q |-> aux_cnt_q == `RMP_AUX_HIGH_CYC)
    else $error("aux high time wrong");
endmodule // rmp_resonant_pwm_props
bind rmp_resonant_pwm rmp_resonant_pwm_props u_props (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_rdata(reg_rdata), .pwm_enable(pwm_enable),
  .fault_in(fault_in), .drive_a(drive_a), .drive_b(drive_b),
  .drive_c(drive_c), .drive_d(drive_d), .aux_drive(aux_drive),
  .burst_active(burst_active), .fault_flag(fault_flag)
);
`default_nettype wire

// ===== test_resonant_mode_pwm_timing.sv
// Self-checking testbench for the resonant mode PWM timing block.
`timescale 1ns/1ps
`default_nettype none
`include "rmp_defines.vh"
module test_resonant_mode_pwm_timing;
  // ****************************************
  // Stimulus and observation.
  // ****************************************
  logic clk, srst, reg_we, pwm_enable, fault_in;
  logic [7:0] reg_addr, reg_wdata, v;
  logic [11:0] vref_target, vsense;
  wire [7:0] reg_rdata;
  wire drive_a, drive_b, drive_c, drive_d, aux_drive, burst_active;
  wire soft_start_done, fault_flag;
  wire [15:0] short_cnt;
  integer err_total = 0, checks = 0, seed = 32'hdf1e, cyc = 0;
  integer i, k, r, n, wa, g, wc, rs, f, e;
  logic [7:0] regs [8] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46,
                           8'h48, 8'h4A};
  rmp_resonant_pwm u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
    .pwm_enable(pwm_enable), .fault_in(fault_in),
    .vref_target(vref_target), .vsense(vsense), .drive_a(drive_a),
    .drive_b(drive_b), .drive_c(drive_c), .drive_d(drive_d),
    .aux_drive(aux_drive), .burst_active(burst_active),
    .soft_start_done(soft_start_done), .fault_flag(fault_flag));
  rmp_switch_model u_sw (.clk(clk), .leg_a(drive_a), .leg_b(drive_b),
    .leg_c(drive_c), .leg_d(drive_d), .short_cnt(short_cnt));
  // Free running 8 ns clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run;
    end
  end
  // Cycles from cycle start to drive A rise for a rise delay count.
  function automatic integer lead(input integer rd);
    lead = (5 * rd + 7) / 8;
  endfunction
  // Cycles from cycle start to drive A fall; trailing falls cut at half.
  function automatic integer fall_cyc(input integer cnt, fd);
    fall_cyc = fd >= 128 ? (40 * cnt - 5 * (256 - fd) + 7) / 8 : 5 * cnt;
  endfunction
  task automatic compare(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = reg_rdata;
  endtask
  // Counts settled cycles until drive A or C reaches a level.
  task automatic wait_lvl(input bit c, input logic lvl, output integer m);
    m = 0;
    while ((c ? drive_c : drive_a) !== lvl && m < 4000) begin
      @(posedge clk);
      #1 m++;
    end
  endtask
  task complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence of scenarios.
  initial begin
    {srst, reg_we, reg_addr, reg_wdata, pwm_enable, fault_in} = 20'h80000;
    vref_target = 12'h020;
    vsense = 12'h000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 compare("ss_early", soft_start_done, 0);
    for (i = 0; i < 8; i++) begin
      rd(regs[i], v);
      compare("reset_reg", v, 0);
    end
    for (i = 0; i < 7; i++) begin
      wr(regs[i], $random(seed));
      rd(regs[i], v);
      compare("rw_reg", v, reg_wdata);
    end
    wr(8'h40, 8'h3E);
    @(posedge clk) pwm_enable <= 1'b1;
    n = 0;
    repeat (200) begin
      @(posedge clk);
      #1 n += drive_a | drive_c;
    end
    compare("mode_off", n, 0);
    wr(8'h3E, 8'hFF);
    wr(8'h40, 8'h3F);
    rd(8'h3E, v);
    compare("status", v, 8'h01);
    for (i = 0; i < 3; i++) begin
      k = 32 + $unsigned($random(seed)) % 32;
      r = $unsigned($random(seed)) % 256;
      f = $unsigned($random(seed)) % 64;
      f = (i == 0) ? 0 : (i == 1) ? 64 + f : 192 + f;
      if (i == 2) begin
        r = r % 128;
      end
      e = fall_cyc(k, f) - lead(r);
      wr(8'h42, k); wr(8'h44, 0); wr(8'h46, k); wr(8'h48, 0);
      wr(8'h41, r); wr(8'h43, f);
      // Restart so the cycle timebase begins on a clean 8 ns grid.
      @(posedge clk) pwm_enable <= 1'b0;
      @(posedge clk) pwm_enable <= 1'b1;
      repeat (i == 0 ? 6000 : 2000) @(posedge clk);
      #1 wait_lvl(0, 0, n);
      wait_lvl(0, 1, n);
      wait_lvl(0, 0, wa); wait_lvl(1, 1, g);
      wait_lvl(1, 0, wc); wait_lvl(0, 1, rs);
      compare("a_high", wa, e);
      compare("c_high", wc, e);
      compare("half_gap", g, 5 * k - e);
      compare("period", wa + g + wc + rs, 10 * k);
    end
    @(posedge clk) fault_in <= 1'b1;
    @(posedge clk) fault_in <= 1'b0;
    repeat (3) @(posedge clk);
    #1 compare("fault", {fault_flag, drive_a, drive_c}, 3'b100);
    rd(8'h3E, v);
    compare("st_fault", v[3], 1);
    @(posedge clk) pwm_enable <= 1'b0;
    @(posedge clk) pwm_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1 compare("fault_clr", fault_flag, 0);
    n = 0;
    while (soft_start_done !== 1'b1 && n < 12000) begin
      @(posedge clk);
      #1 n++;
    end
    compare("ss_done", soft_start_done, 1);
    @(posedge clk) vsense <= 12'hFFF;
    wr(8'h46, 8'h01); wr(8'h48, 0); wr(8'h42, 8'hFF); wr(8'h44, 8'hF0);
    wr(8'h41, 0); wr(8'h43, 0);
    repeat (8000) @(posedge clk);
    #1 wait_lvl(0, 0, n);
    wait_lvl(0, 1, n);
    wait_lvl(0, 0, wa); wait_lvl(0, 1, rs);
    compare("min_clamp", wa + rs, 10);
    compare("no_burst", burst_active, 0);
    wr(8'h4A, 8'h44);
    rd(8'h4A, v);
    compare("burst_reg", v, 8'h44);
    repeat (700) @(posedge clk);
    #1 compare("burst_on", {burst_active, drive_a, drive_c}, 3'b100);
    @(posedge clk) vsense <= 12'h000;
    n = 0;
    while (burst_active !== 1'b0 && n < 9000) begin
      @(posedge clk);
      #1 n++;
    end
    compare("exit_win", n > 21 * 312 && n <= 22 * 312, 1);
    wait_lvl(0, 1, n);
    compare("resume", drive_a, 1);
    compare("shoot", short_cnt, 0);
    complete_run;
  end
endmodule // test_resonant_mode_pwm_timing
`default_nettype wire
